// ---- design/exec_pkg.sv ----
// Constants and types shared by the instruction execution block
// Functional notes
// - Decrement-skip opcode decrements file, flags untouched
// - Destination bit zero selects accumulator
// - Nonzero result discards prefetch, adds no-op
// - Skipped two-word instruction costs two no-ops
// - Bank bit selects common or banked file
// - Extended set, low operand uses indexed offset
// - Increment-skip opcode increments file, flags untouched
// - Absolute jump loads twenty literal bits
// - Jump takes two cycles, second one idle
// - OR literal into accumulator, update N Z
// - Load pointer: two words, three pointers
package exec_pkg;
   localparam logic [5:0]  OP_DEC_SKIP    = 6'h13;
   localparam logic [5:0]  OP_INC_SKIP    = 6'h12;
   localparam logic [5:0]  OP_OR_FILE     = 6'h04;
   localparam logic [7:0]  OP_OR_LIT      = 8'h09;
   localparam logic [7:0]  OP_JUMP        = 8'hef;
   localparam logic [7:0]  OP_LOAD_PTR    = 8'hee;
   localparam logic [3:0]  SECOND_WORD    = 4'hf;
   localparam logic [7:0]  INDEXED_LIMIT  = 8'h5f;
   localparam logic [7:0]  COMMON_LOW_TOP = 8'h5f;
   localparam logic [5:0]  COMMON_HI_BANK = 6'h3f;
   localparam logic [5:0]  COMMON_LO_BANK = 6'h00;
   localparam logic [1:0]  PTR_COUNT      = 2'h3;
   localparam logic [7:0]  ACC_RESET      = 8'h00;
   localparam logic [13:0] PTR_RESET      = 14'h0000;
   localparam logic [20:0] PC_RESET       = 21'h000000;
   localparam int          DEST_BIT       = 9;
   localparam int          BANK_BIT       = 8;
   typedef enum logic [1:0] {Q1, Q2, Q3, Q4} phase_type;
   typedef enum logic [2:0] {
      EXEC, FLUSH_ONE, FLUSH_TWO, JUMP_IDLE, PTR_LOW
   } cycle_type;
endpackage

// ---- design/file_port_if.sv ----
// Data-file access channel between executor and address resolver
`timescale 1ns/1ps
`default_nettype none
interface file_port_if;
   logic [7:0]  operand;
   logic        bank_sel;
   logic        ext_enable;
   logic [5:0]  bank_pointer;
   logic [13:0] index_base;
   logic [13:0] address;
   logic        indexed;
   modport requester (output operand, bank_sel, ext_enable, bank_pointer, index_base,
                      input address, indexed);
   modport resolver (input operand, bank_sel, ext_enable, bank_pointer, index_base,
                     output address, indexed);
endinterface
`default_nettype wire

// ---- design/file_addr_resolve.sv ----
// Resolves an 8-bit file operand into a 14-bit data address
`timescale 1ns/1ps
`default_nettype none
module file_addr_resolve (
   file_port_if.resolver fp
);
   import exec_pkg::*;
   wire use_indexed;
   wire [5:0] common_bank;
   assign use_indexed = !fp.bank_sel && fp.ext_enable
                        && (fp.operand <= INDEXED_LIMIT);
   // Common bank: operands up to 0x5F in bank zero, the rest in the top bank
   assign common_bank = (fp.operand <= COMMON_LOW_TOP) ? COMMON_LO_BANK : COMMON_HI_BANK;
   assign fp.indexed = use_indexed;
   assign fp.address = use_indexed ? fp.index_base + {6'h00, fp.operand}
                     : fp.bank_sel ? {fp.bank_pointer, fp.operand}
                     : {common_bank, fp.operand};
endmodule
`default_nettype wire

// ---- design/phase_gen.sv ----
// Four-phase sequencer of the instruction cycle
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
   input  wire logic              core_clk,
   input  wire logic              rst,
   output var  exec_pkg::phase_type phase,
   output logic                    cycle_end
);
   import exec_pkg::*;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase <= Q1;
      end else begin
         phase <= phase_type'(phase + 2'd1);
      end
   end
   assign cycle_end = (phase == Q4);
endmodule
`default_nettype wire

// ---- design/skip_branch_or_pointer_exec.sv ----
// Executes skip, jump, OR and pointer-load instructions over four phases
`timescale 1ns/1ps
`default_nettype none
module skip_branch_or_pointer_exec (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic [15:0] instr_word,
   input  wire logic        instr_valid,
   input  wire logic        next_is_two_word,
   input  wire logic        ext_enable,
   input  wire logic [5:0]  bank_pointer,
   input  wire logic [7:0]  file_rdata,
   output logic [13:0]      file_addr,
   output logic             file_addr_indexed,
   output logic             file_we,
   output logic [7:0]       file_wdata,
   output logic [7:0]       acc,
   output logic             flag_neg,
   output logic             flag_zero,
   output logic [20:0]      pc,
   output logic             pc_load,
   output logic             prefetch_discard,
   output logic             nop_cycle,
   output logic [13:0]      ptr0,
   output logic [13:0]      ptr1,
   output logic [13:0]      ptr2,
   output logic [1:0]       exec_phase
);
   import exec_pkg::*;

   phase_type phase;
   logic      cycle_end;
   phase_gen u_phase (
      .core_clk  (core_clk),
      .rst       (rst),
      .phase     (phase),
      .cycle_end (cycle_end)
   );

   file_port_if fp ();
   file_addr_resolve u_resolve (.fp(fp));

   cycle_type   state_q, state_d;
   logic [15:0] ir_q;
   logic [15:0] second_q;
   logic [7:0]  operand_q, result_q;
   logic [7:0]  acc_q, acc_d;
   logic        neg_q, zero_q;
   logic [20:0] pc_q;
   logic        pc_load_q;
   logic [7:0]  jump_low_q;
   logic [1:0]  ptr_sel_q;
   logic [13:0] ptr_q [PTR_COUNT];
   logic        we_q;
   logic [7:0]  wdata_q;
   logic [13:0] addr_q;
   logic        indexed_q;
   logic        discard_q;

   // Opcode decode on the captured word
   wire [5:0] op6       = ir_q[15:10];
   wire       dest_file = ir_q[DEST_BIT];
   wire       is_dec    = (op6 == OP_DEC_SKIP);
   wire       is_inc    = (op6 == OP_INC_SKIP);
   wire       is_or_f   = (op6 == OP_OR_FILE);
   wire       is_or_l   = (ir_q[15:8] == OP_OR_LIT);
   wire       is_jump   = (ir_q[15:8] == OP_JUMP);
   wire       is_lptr   = (ir_q[15:8] == OP_LOAD_PTR) && (ir_q[5:4] != PTR_COUNT);
   wire       is_file   = is_dec || is_inc || is_or_f;
   wire       second_ok = (instr_word[15:12] == SECOND_WORD);
   wire [15:0] ir_next  = (state_q == EXEC && instr_valid) ? instr_word : 16'h0000;

   // Arithmetic; skip ops leave flags alone
   wire [7:0] dec_val   = file_rdata - 8'h01;
   wire [7:0] inc_val   = file_rdata + 8'h01;
   wire [7:0] or_f_val  = acc_q | file_rdata;
   wire [7:0] or_l_val  = acc_q | operand_q;
   wire [7:0] alu_val   = is_dec ? dec_val : is_inc ? inc_val : or_f_val;
   wire       skip_take = (is_dec || is_inc) && (result_q != 8'h00);

   // Phase strobes of an executing cycle
   wire       exec_q2   = (state_q == EXEC) && (phase == Q2);
   wire       exec_q3   = (state_q == EXEC) && (phase == Q3);
   wire       exec_q4   = (state_q == EXEC) && (phase == Q4);
   wire       jump_take = (state_q == JUMP_IDLE) && (phase == Q1) && second_ok;
   // Only inserted cycles count as no-ops; the pointer's second word does work
   wire       nop_state = (state_q == FLUSH_ONE) || (state_q == FLUSH_TWO)
                          || (state_q == JUMP_IDLE);
   wire       ptr2_byp  = (state_q == PTR_LOW) && (ptr_sel_q == 2'h2) && (phase != Q1);
   wire [13:0] ptr2_view = ptr2_byp ? {ptr_q[2][13:8], second_q[7:0]} : ptr_q[2];

   assign fp.operand      = ir_q[7:0];
   assign fp.bank_sel     = ir_q[BANK_BIT];
   assign fp.ext_enable   = ext_enable;
   assign fp.bank_pointer = bank_pointer;
   assign fp.index_base   = ptr_q[2];

   // Next-cycle selection at the end of Q4
   always_comb begin
      state_d = EXEC;
      unique case (state_q)
         EXEC: begin
            if (skip_take) begin
               state_d = FLUSH_ONE;
            end else if (is_jump) begin
               state_d = JUMP_IDLE;
            end else if (is_lptr) begin
               state_d = PTR_LOW;
            end
         end
         FLUSH_ONE: begin
            state_d = next_is_two_word ? FLUSH_TWO : EXEC;
         end
         FLUSH_TWO, JUMP_IDLE, PTR_LOW: begin
            state_d = EXEC;
         end
      endcase
   end

   always_comb begin
      acc_d = acc_q;
      if (state_q == EXEC && phase == Q4) begin
         if (is_or_l) begin
            acc_d = result_q;
         end else if (is_file && !dest_file) begin
            acc_d = result_q;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= EXEC;
         ir_q    <= 16'h0000;
      end else begin
         if (cycle_end) begin
            state_q <= state_d;
         end
         // Empty slot becomes a no-op, so a held word never runs twice
         if (phase == Q1) begin
            ir_q <= ir_next;
         end
      end
   end

   // Address is captured in Q2, before the file value is needed
   always_ff @(posedge core_clk) begin
      if (rst) begin
         operand_q <= 8'h00;
         addr_q    <= 14'h0000;
         indexed_q <= 1'b0;
      end else if (exec_q2) begin
         operand_q <= ir_q[7:0];
         addr_q    <= fp.address;
         indexed_q <= fp.indexed;
      end
   end

   // File value must be valid by Q3
   always_ff @(posedge core_clk) begin
      if (rst) begin
         result_q <= 8'h00;
      end else if (exec_q3) begin
         result_q <= is_or_l ? or_l_val : alu_val;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_q  <= ACC_RESET;
         neg_q  <= 1'b0;
         zero_q <= 1'b0;
      end else begin
         acc_q <= acc_d;
         // Skip ops must leave the flags alone
         if (exec_q4 && (is_or_l || is_or_f)) begin
            neg_q  <= result_q[7];
            zero_q <= (result_q == 8'h00);
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         we_q      <= 1'b0;
         wdata_q   <= 8'h00;
         discard_q <= 1'b0;
      end else begin
         we_q      <= exec_q4 && is_file && dest_file;
         discard_q <= cycle_end && (state_q == EXEC) && skip_take;
         if (exec_q4) begin
            wdata_q <= result_q;
         end
      end
   end

   // Jump: low byte in Q2, high bits plus write at the next Q1
   always_ff @(posedge core_clk) begin
      if (rst) begin
         jump_low_q <= 8'h00;
      end else if (exec_q2 && is_jump) begin
         jump_low_q <= ir_q[7:0];
      end
   end

   // A second word without the 1111 prefix leaves the counter alone
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pc_q      <= PC_RESET;
         pc_load_q <= 1'b0;
      end else begin
         pc_load_q <= jump_take;
         if (jump_take) begin
            pc_q <= {instr_word[11:0], jump_low_q, 1'b0};
         end
      end
   end

   // Pointer load, one pointer per entry
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ptr_sel_q <= 2'h0;
      end else if (state_q == EXEC && is_lptr && phase == Q2) begin
         ptr_sel_q <= ir_q[5:4];
      end
   end

   genvar g;
   generate
      for (g = 0; g < PTR_COUNT; g++) begin : g_ptr
         always_ff @(posedge core_clk) begin
            if (rst) begin
               ptr_q[g] <= PTR_RESET;
            end else if (phase == Q4 && ptr_sel_q == 2'(g)) begin
               if (state_q == EXEC && is_lptr) begin
                  ptr_q[g][13:8] <= ir_q[3:0] == 4'h0 ? 6'h00 : {2'b00, ir_q[3:0]};
               end else if (state_q == PTR_LOW) begin
                  ptr_q[g][7:0] <= second_q[7:0];
               end
            end
         end
      end
   endgenerate

   // Second word of the pointer load, held for its low byte
   always_ff @(posedge core_clk) begin
      if (rst) begin
         second_q <= 16'h0000;
      end else if (phase == Q1 && state_q == PTR_LOW) begin
         second_q <= instr_word;
      end
   end

   // Registered outputs: file port
   always_ff @(posedge core_clk) begin
      if (rst) begin
         file_addr         <= 14'h0000;
         file_addr_indexed <= 1'b0;
         file_we           <= 1'b0;
         file_wdata        <= 8'h00;
      end else begin
         file_addr         <= addr_q;
         file_addr_indexed <= indexed_q;
         file_we           <= we_q;
         file_wdata        <= wdata_q;
      end
   end

   // Registered outputs: core state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc       <= ACC_RESET;
         flag_neg  <= 1'b0;
         flag_zero <= 1'b0;
         pc        <= PC_RESET;
         pc_load   <= 1'b0;
      end else begin
         acc       <= acc_q;
         flag_neg  <= neg_q;
         flag_zero <= zero_q;
         pc        <= pc_q;
         pc_load   <= pc_load_q;
      end
   end

   // Registered outputs: sequencing and pointers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prefetch_discard <= 1'b0;
         nop_cycle        <= 1'b0;
         ptr0             <= PTR_RESET;
         ptr1             <= PTR_RESET;
         ptr2             <= PTR_RESET;
         exec_phase       <= 2'h0;
      end else begin
         prefetch_discard <= discard_q;
         nop_cycle        <= nop_state;
         ptr0             <= ptr_q[0];
         ptr1             <= ptr_q[1];
         ptr2             <= ptr2_view;
         exec_phase       <= phase;
      end
   end
endmodule
`default_nettype wire

// ---- bench/exec_assertions.sv ----
// Port-level temporal checks for the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module exec_assertions (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic        file_we,
   input wire logic [7:0]  acc,
   input wire logic [20:0] pc,
   input wire logic        prefetch_discard,
   input wire logic        nop_cycle,
   input wire logic [13:0] ptr0,
   input wire logic [1:0]  exec_phase
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // First edge after release still sees reset values in $past
   a_phase_steps_on: assert property (
      !$past(rst) && !$past(rst, 2) |-> exec_phase == $past(exec_phase) + 2'h1)
      else $error("phase did not step by one");
   a_reset_zeroes: assert property (
      $past(rst) |-> acc == 8'h00 && pc == 21'h000000 && ptr0 == 14'h0000 && !file_we)
      else $error("outputs not cleared by reset");
   a_pc_word_even: assert property (pc[0] == 1'b0)
      else $error("jump target has bit zero set");
   a_write_one_pulse: assert property (file_we |=> !file_we)
      else $error("file write longer than one cycle");
   a_discard_one_pulse: assert property (
      prefetch_discard |=> !prefetch_discard)
      else $error("discard pulse longer than one cycle");
   a_discard_brings_nop: assert property (
      prefetch_discard |-> ##[0:4] nop_cycle)
      else $error("discard without inserted no-op");
   a_nop_whole_cycle: assert property ($rose(nop_cycle) |-> nop_cycle[*4])
      else $error("no-op shorter than four phases");
   a_nop_two_at_most: assert property (nop_cycle[*8] |=> !nop_cycle)
      else $error("more than two no-op cycles");
endmodule
bind skip_branch_or_pointer_exec exec_assertions chk_u (
   .core_clk, .rst, .file_we, .acc, .pc, .prefetch_discard, .nop_cycle, .ptr0, .exec_phase
);
`default_nettype wire

// ---- bench/skip_branch_or_pointer_exec_tb.sv ----
// Randomised self-checking bench for the instruction execution block
`timescale 1ns/1ps
`default_nettype none
module skip_branch_or_pointer_exec_tb;
   import exec_pkg::*;
   logic        core_clk, rst, instr_valid, next_is_two_word, ext_enable;
   logic        file_addr_indexed, file_we, flag_neg, flag_zero, pc_load;
   logic        prefetch_discard, nop_cycle, wi, ez, en, d, a, two, ix, sk;
   logic [15:0] instr_word;
   logic [5:0]  bank_pointer;
   logic [7:0]  file_rdata, file_wdata, acc, ea, wd, f, rd, res, lit;
   logic [13:0] file_addr, ptr0, ptr1, ptr2, wa;
   logic [13:0] ep [0:3];
   logic [20:0] pc, epc;
   logic [19:0] k;
   logic [1:0]  exec_phase, sel;
   logic [31:0] seed, r;
   int          n_errors, total_checks, wcnt, dcnt, ncnt, lcnt, cyc, i, op;

   skip_branch_or_pointer_exec dut_u (
      .core_clk, .rst, .instr_word, .instr_valid, .next_is_two_word, .ext_enable,
      .bank_pointer, .file_rdata, .file_addr, .file_addr_indexed, .file_we, .file_wdata,
      .acc, .flag_neg, .flag_zero, .pc, .pc_load, .prefetch_discard, .nop_cycle,
      .ptr0, .ptr1, .ptr2, .exec_phase
   );

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [13:0] exp_addr(input logic [7:0] fo, input logic ab);
      if (ab)
         return {bank_pointer, fo};
      return {(fo <= COMMON_LOW_TOP) ? COMMON_LO_BANK : COMMON_HI_BANK, fo};
   endfunction

   task automatic chk_v(input logic [47:0] g, input logic [47:0] e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Waits for the capture slot, then holds each word for one whole four-phase cycle
   task automatic run(input logic [15:0] w1, input logic [15:0] w2, input logic v2);
      int n;
      n = 0;
      @(negedge core_clk);
      while (exec_phase !== 2'h3 && n < 8) begin
         @(negedge core_clk);
         n++;
      end
      @(posedge core_clk);
      wcnt = 0;
      dcnt = 0;
      ncnt = 0;
      lcnt = 0;
      instr_word <= w1;
      instr_valid <= 1'b1;
      repeat (4) @(posedge core_clk);
      instr_word <= w2;
      instr_valid <= v2;
      repeat (4) @(posedge core_clk);
      instr_valid <= 1'b0;
      repeat (16) @(posedge core_clk);
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Sampled off the launching edge so registered outputs have settled
   always @(negedge core_clk) begin
      if (file_we === 1'b1) begin
         wcnt++;
         wd = file_wdata;
         wa = file_addr;
         wi = file_addr_indexed;
      end
      if (prefetch_discard === 1'b1)
         dcnt++;
      if (nop_cycle === 1'b1)
         ncnt++;
      if (pc_load === 1'b1)
         lcnt++;
      cyc++;
      if (cyc == 4000) begin
         n_errors++;
         give_verdict();
      end
   end

   initial begin
      {rst, instr_valid, next_is_two_word, ext_enable} = 4'hf;
      {instr_word, bank_pointer, file_rdata} = 30'h0;
      {n_errors, total_checks, cyc} = 0;
      {ea, ez, en, epc} = 31'h0;
      ep = '{default: 14'h0000};
      instr_valid = 1'b0;
      seed = 32'he58f;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      for (i = 0; i < 60; i++) begin
         r = xs();
         op = (i < 12) ? i % 6 : int'(r[30:28]) % 6;
         {f, d, a, two, lit, k, sel} = {r[15:8], r[16], r[17], r[18], r[31:24], r[27:8], r[1:0]};
         rd = (i % 5 == 0) ? ((op == 2) ? 8'h01 : 8'hff) : r[7:0];
         ix = !a && r[19] && f <= INDEXED_LIMIT;
         ext_enable <= r[19];
         bank_pointer <= r[25:20];
         file_rdata <= rd;
         next_is_two_word <= two;
         case (op)
            0: begin
               ea = ea | lit;
               {en, ez} = {ea[7], ea == 8'h00};
               run({OP_OR_LIT, lit}, 16'h0000, 1'b0);
            end
            1: begin
               res = ea | rd;
               {en, ez} = {res[7], res == 8'h00};
               ea = d ? ea : res;
               run({OP_OR_FILE, d, a, f}, 16'h0000, 1'b0);
            end
            2, 3: begin
               res = (op == 2) ? rd - 8'h01 : rd + 8'h01;
               sk = res != 8'h00;
               run({(op == 2) ? OP_DEC_SKIP : OP_INC_SKIP, d, a, f}, {OP_OR_LIT, 8'h80}, 1'b1);
               ea = d ? ea : res;
               if (!sk)
                  {ea, en, ez} = {ea | 8'h80, 2'b10};
               chk_v(48'(dcnt), 48'(sk));
               chk_v(48'(ncnt), sk ? (two ? 48'h8 : 48'h4) : 48'h0);
            end
            4: begin
               run({OP_JUMP, k[7:0]}, {SECOND_WORD, k[19:8]}, 1'b1);
               epc = {1'b0, k} << 1;
               chk_v(48'(ncnt), 48'h4);
            end
            default: begin
               // Upper two literal bits left clear: the high nibble carries bits 11..8
               k[13:12] = 2'b00;
               run({OP_LOAD_PTR, 2'b00, sel, k[11:8]}, {SECOND_WORD, 4'h0, k[7:0]}, 1'b1);
               if (sel != 2'h3)
                  ep[sel] = k[13:0];
               chk_v(48'(ncnt), 48'h0);
            end
         endcase
         if (op inside {[1:3]}) begin
            chk_v(48'(wcnt), 48'(d));
            if (d) begin
               chk_v(48'(wd), 48'(res));
               chk_v(48'(wi), 48'(ix));
               chk_v(48'(wa), 48'(ix ? ep[2] + 14'(f) : exp_addr(f, a)));
            end
         end
         chk_v(48'(acc), 48'(ea));
         chk_v(48'({flag_neg, flag_zero}), 48'({en, ez}));
         chk_v(48'(pc), 48'(epc));
         chk_v(48'(lcnt), 48'(op == 4));
         chk_v({6'h00, ptr2, ptr1, ptr0}, {6'h00, ep[2], ep[1], ep[0]});
         $display("op %0d kind %0d done", i, op);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
